// file: hdl/rcot_consts.vh
// constants of the reset-cause, oscillator-trim and pin-direction bank
// assumes inclusion by bare name from the design files
`ifndef RCOT_CONSTS_VH
`define RCOT_CONSTS_VH
// =======================================
// register byte addresses
`define RCOT_ADDR_RESET_CAUSE 8'h8e
`define RCOT_ADDR_OSC_TRIM 8'h90
`define RCOT_ADDR_PIN_DIR 8'h94
`define RCOT_ADDR_EXT_CAUSE 8'h98
`define RCOT_ADDR_IRQ_STATUS 8'h9c
`define RCOT_ADDR_IRQ_MASK 8'ha0
// =======================================
// field positions
`define RCOT_BIT_BROWNOUT 0
`define RCOT_BIT_POWERON 1
`define RCOT_BIT_WATCHDOG 0
`define RCOT_BIT_EXTPIN 1
`define RCOT_TRIM_MSB 7
`define RCOT_TRIM_LSB 2
`define RCOT_PIN3 3
// =======================================
// reset values and oscillator target frequency
`define RCOT_TRIM_RESET 6'h20
`define RCOT_DIR_RESET 6'h3f
`define RCOT_OSC_TARGET_KHZ 4000
`endif

// file: hdl/rcot_event_sync.v
// two-flop synchroniser with rising edge pulse
// assumes asynchronous level input, single clock
`timescale 1ns/100ps
module rcot_event_sync (
    // clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // level in, pulse out
    input wire level_in,
    output wire pulse_out
);
    reg meta_q;
    reg sync_q;
    reg last_q;
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            meta_q <= 1'b0;
            sync_q <= 1'b0;
            last_q <= 1'b0;
        end else begin
            meta_q <= level_in;
            sync_q <= meta_q;
            last_q <= sync_q;
        end
    end
    assign pulse_out = sync_q & ~last_q;
endmodule

// file: hdl/rcot_pin_drive.v
// per-pin driver enables from direction bits
// assumes direction 1 means input
`timescale 1ns/100ps
`include "rcot_consts.vh"
module rcot_pin_drive (
    // direction and data
    input wire [5:0] dir_in,
    input wire [5:0] data_in,
    // pad side
    output wire [5:0] pad_out,
    output wire [5:0] pad_oe_out
);
    assign pad_out = data_in;
    assign pad_oe_out = ~dir_in;
endmodule

// file: hdl/rcot_regs.v
// register bank: reset cause flags, oscillator trim, pin direction
// assumes Avalon-MM master on clock_in, event levels from detectors
//
// Our own choice: register access over Avalon-MM.
`timescale 1ns/100ps
`include "rcot_consts.vh"
module rcot_regs (
    // clock and reset
    input wire clock_in,
    input wire rst_n_in,
    // avalon-mm slave
    input wire [7:0] avs_address_in,
    input wire avs_read_in,
    input wire avs_write_in,
    input wire [31:0] avs_writedata_in,
    input wire [3:0] avs_byteenable_in,
    output reg [31:0] avs_readdata_out,
    output wire avs_waitrequest_out,
    output reg [1:0] avs_response_out,
    // reset source events, asynchronous levels
    input wire poweron_event_in,
    input wire brownout_event_in,
    input wire watchdog_timer_event_in,
    input wire external_reset_pin_event_in,
    // oscillator calibration
    output wire [5:0] trim_code_out,
    // port pads
    input wire [5:0] pin_data_in,
    output wire [5:0] pin_out,
    output wire [5:0] pin_oe_out,
    output wire [5:0] pin_direction_out,
    // interrupt
    output wire irq_out
);
    // =======================================
    // event capture
    wire por_p;
    wire bod_p;
    wire wdt_p;
    wire ext_p;
    rcot_event_sync u_por (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .level_in(poweron_event_in), .pulse_out(por_p));
    rcot_event_sync u_bod (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .level_in(brownout_event_in), .pulse_out(bod_p));
    rcot_event_sync u_wdt (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .level_in(watchdog_timer_event_in), .pulse_out(wdt_p));
    rcot_event_sync u_ext (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .level_in(external_reset_pin_event_in), .pulse_out(ext_p));
    // =======================================
    // bus handshake: one wait cycle per access
    reg ack_q;
    wire req = (avs_read_in | avs_write_in) & ~ack_q;
    assign avs_waitrequest_out = (avs_read_in | avs_write_in) & ~ack_q;
    wire take = (avs_read_in | avs_write_in) & ack_q;
    wire wr = avs_write_in & ack_q & avs_byteenable_in[0];
    wire [7:0] wd = avs_writedata_in[7:0];
    function is_mapped;
        input [7:0] a;
        begin
            is_mapped = (a == `RCOT_ADDR_RESET_CAUSE) | (a == `RCOT_ADDR_OSC_TRIM) |
                (a == `RCOT_ADDR_PIN_DIR) | (a == `RCOT_ADDR_EXT_CAUSE) |
                (a == `RCOT_ADDR_IRQ_STATUS) | (a == `RCOT_ADDR_IRQ_MASK);
        end
    endfunction
    // =======================================
    // registers
    reg poweron_flag_q;
    reg brownout_flag_q;
    reg watchdog_flag_q;
    reg extpin_flag_q;
    reg [5:0] trim_q;
    reg [5:0] dir_q;
    reg [3:0] irq_stat_q;
    reg [3:0] irq_mask_q;
    wire wr_cause = wr & (avs_address_in == `RCOT_ADDR_RESET_CAUSE);
    wire wr_ext = wr & (avs_address_in == `RCOT_ADDR_EXT_CAUSE);
    wire wr_stat = wr & (avs_address_in == `RCOT_ADDR_IRQ_STATUS);
    wire [3:0] ev = {ext_p, wdt_p, por_p, bod_p};
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            ack_q <= 1'b0;
            poweron_flag_q <= 1'b1;
            brownout_flag_q <= 1'b1;
            watchdog_flag_q <= 1'b1;
            extpin_flag_q <= 1'b1;
            trim_q <= `RCOT_TRIM_RESET;
            dir_q <= `RCOT_DIR_RESET;
            irq_stat_q <= 4'h0;
            irq_mask_q <= 4'h0;
        end else begin
            ack_q <= req;
            // event wins over software re-arm
            if (por_p)
                poweron_flag_q <= 1'b0;
            else if (wr_cause && wd[`RCOT_BIT_POWERON])
                poweron_flag_q <= 1'b1;
            if (bod_p)
                brownout_flag_q <= 1'b0;
            else if (wr_cause && wd[`RCOT_BIT_BROWNOUT])
                brownout_flag_q <= 1'b1;
            if (wdt_p)
                watchdog_flag_q <= 1'b0;
            else if (wr_ext && wd[`RCOT_BIT_WATCHDOG])
                watchdog_flag_q <= 1'b1;
            if (ext_p)
                extpin_flag_q <= 1'b0;
            else if (wr_ext && wd[`RCOT_BIT_EXTPIN])
                extpin_flag_q <= 1'b1;
            if (wr && avs_address_in == `RCOT_ADDR_OSC_TRIM)
                trim_q <= wd[`RCOT_TRIM_MSB:`RCOT_TRIM_LSB];
            if (wr && avs_address_in == `RCOT_ADDR_PIN_DIR)
                dir_q <= wd[5:0];
            if (wr && avs_address_in == `RCOT_ADDR_IRQ_MASK)
                irq_mask_q <= wd[3:0];
            irq_stat_q <= (irq_stat_q & ~(wr_stat ? wd[3:0] : 4'h0)) | ev;
        end
    end
    // =======================================
    // outputs
    wire [5:0] dir_eff = dir_q | 6'h08;
    assign pin_direction_out = dir_eff;
    assign trim_code_out = trim_q;
    assign irq_out = |(irq_stat_q & irq_mask_q);
    rcot_pin_drive u_drive (.dir_in(dir_eff), .data_in(pin_data_in),
        .pad_out(pin_out), .pad_oe_out(pin_oe_out));
    // =======================================
    // read data
    reg [7:0] rd;
    always @* begin
        rd = 8'h00;
        case (avs_address_in)
            `RCOT_ADDR_RESET_CAUSE: rd = {6'h00, poweron_flag_q, brownout_flag_q};
            `RCOT_ADDR_OSC_TRIM: rd = {trim_q, 2'b00};
            `RCOT_ADDR_PIN_DIR: rd = {2'b00, dir_eff};
            `RCOT_ADDR_EXT_CAUSE: rd = {6'h00, extpin_flag_q, watchdog_flag_q};
            `RCOT_ADDR_IRQ_STATUS: rd = {4'h0, irq_stat_q};
            `RCOT_ADDR_IRQ_MASK: rd = {4'h0, irq_mask_q};
            default: rd = 8'h00;
        endcase
    end
    always @(posedge clock_in) begin
        if (!rst_n_in) begin
            avs_readdata_out <= 32'h0000_0000;
            avs_response_out <= 2'b00;
        end else if (req) begin
            avs_readdata_out <= {24'h00_0000, rd};
            avs_response_out <= is_mapped(avs_address_in) ? 2'b00 : 2'b11;
        end
    end
    wire unused_ok = take;
endmodule

// file: dv/rcot_regs_checker.sv
// checker of port relations of the register bank
// assumes binding onto rcot_regs, one clock domain
`timescale 1ns/100ps
module rcot_regs_checker (
    input wire clock_in, rst_n_in, avs_read_in, avs_write_in, avs_waitrequest_out,
    input wire [7:0] avs_address_in,
    input wire [3:0] avs_byteenable_in,
    input wire [31:0] avs_writedata_in, avs_readdata_out,
    input wire [5:0] trim_code_out, pin_oe_out, pin_direction_out
);
    default clocking @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    sequence s_rd(a);
        avs_read_in && !avs_waitrequest_out && avs_address_in == a;
    endsequence
    sequence s_wt;
        avs_write_in && !avs_waitrequest_out && avs_address_in == 8'h90 && avs_byteenable_in[0];
    endsequence
    property p_wait; avs_read_in && avs_waitrequest_out |=> !avs_waitrequest_out; endproperty
    property p_cause; s_rd(8'h8e) |-> avs_readdata_out[31:2] == 30'h0; endproperty
    property p_tlo; s_rd(8'h90) |-> avs_readdata_out[7:0] == {trim_code_out, 2'b00}; endproperty
    property p_drd; s_rd(8'h94) |-> avs_readdata_out[7:0] == {2'b00, pin_direction_out}; endproperty
    property p_tw; s_wt |=> trim_code_out == $past(avs_writedata_in[7:2]); endproperty
    property p_ts; !(avs_write_in && avs_address_in == 8'h90) |=> $stable(trim_code_out); endproperty
    property p_d3; pin_direction_out[3]; endproperty
    property p_oe; pin_oe_out == ~pin_direction_out; endproperty
    a_wait: assert property (p_wait) else $error("wait not one cycle");
    a_cause: assert property (p_cause) else $error("cause upper bits set");
    a_tlo: assert property (p_tlo) else $error("trim read wrong");
    a_drd: assert property (p_drd) else $error("direction read wrong");
    a_tw: assert property (p_tw) else $error("trim write lost");
    a_ts: assert property (p_ts) else $error("trim changed unasked");
    a_d3: assert property (p_d3) else $error("pin3 not input");
    a_oe: assert property (p_oe) else $error("enable not inverse");
endmodule
bind rcot_regs rcot_regs_checker u_chk (.*);

// file: dv/rcot_regs_tb_top.sv
// bench of the register bank over avalon-mm
// assumes rcot_regs with bound checker
`timescale 1ns/100ps
module rcot_regs_tb_top;
    reg clock_in = 1'b0, rst_n_in = 1'b0, avs_read_in = 1'b0, avs_write_in = 1'b0;
    reg [7:0] avs_address_in = 8'h00, v;
    reg [31:0] avs_writedata_in = 32'h0000_0000, lfsr = 32'h0000_3ec3;
    reg [3:0] avs_byteenable_in = 4'hf, ev = 4'h0;
    reg [5:0] pin_data_in = 6'h00;
    wire [31:0] avs_readdata_out;
    wire avs_waitrequest_out, irq_out;
    wire [1:0] avs_response_out;
    wire [5:0] trim_code_out, pin_out, pin_oe_out, pin_direction_out;
    wire brownout_event_in = ev[0], poweron_event_in = ev[1];
    wire watchdog_timer_event_in = ev[2], external_reset_pin_event_in = ev[3];
    reg [9:0] q[$];
    integer n_fail = 0, compares = 0, i, k, t;
    always #2.5 clock_in = ~clock_in;
    rcot_regs u_dut (.*);
    task chk(input [31:0] nm, input [9:0] s, input [9:0] e);
        compares = compares + 1;
        if (s !== e) begin
            n_fail = n_fail + 1;
            $display("MISMATCH %0s exp %h seen %h", nm, e, s);
        end
    endtask
    task results;
        $display("compares %0d n_fail %0d", compares, n_fail);
        if (n_fail == 0 && compares > 0) $display("STATUS OK");
        else $display("STATUS NOT OK");
        $finish;
    endtask
    task bus(input [7:0] a, input w, input [7:0] d, input [9:0] e);
        if (!w) q.push_back(e);
        @(posedge clock_in);
        avs_address_in <= a;
        avs_read_in <= !w;
        avs_write_in <= w;
        avs_writedata_in <= {24'h00_0000, d};
        t = 0;
        @(posedge clock_in);
        while (avs_waitrequest_out && t < 20) begin
            @(posedge clock_in);
            t = t + 1;
        end
        if (t == 20) begin
            n_fail = n_fail + 1;
            results;
        end
        avs_read_in <= 1'b0;
        avs_write_in <= 1'b0;
    endtask
    always @(posedge clock_in) begin
        if (avs_read_in && !avs_waitrequest_out && q.size() > 0) begin
            chk("read", {avs_response_out, avs_readdata_out[7:0]}, q.pop_front());
        end
    end
    initial begin
        repeat (2) @(posedge clock_in);
        rst_n_in <= 1'b1;
        bus(8'h8e, 1'b0, 8'h00, 10'h003);
        bus(8'h90, 1'b0, 8'h00, 10'h080);
        bus(8'h94, 1'b0, 8'h00, 10'h03f);
        bus(8'h40, 1'b0, 8'h00, 10'h300);
        bus(8'ha0, 1'b1, 8'h0a, 10'h000);
        for (k = 0; k < 4; k = k + 1) begin
            @(posedge clock_in);
            ev[k] <= 1'b1;
            repeat (6) @(posedge clock_in);
            ev[k] <= 1'b0;
            bus(k < 2 ? 8'h8e : 8'h98, 1'b0, 8'h00, {8'h00, 2'b11 ^ (2'b01 << k[0])});
            chk("irq", {9'h000, irq_out}, {9'h000, k[0]});
            bus(k < 2 ? 8'h8e : 8'h98, 1'b1, 8'h03, 10'h000);
            bus(k < 2 ? 8'h8e : 8'h98, 1'b0, 8'h00, 10'h003);
            bus(8'h9c, 1'b1, 8'h01 << k, 10'h000);
            @(negedge clock_in);
            chk("irq", {9'h000, irq_out}, 10'h000);
        end
        for (i = 0; i < 10; i = i + 1) begin
            lfsr = {lfsr[30:0], lfsr[31] ^ lfsr[21] ^ lfsr[1] ^ lfsr[0]};
            v = i == 0 ? 8'h00 : i == 1 ? 8'h80 : lfsr[7:0];
            pin_data_in <= lfsr[13:8];
            bus(8'h90, 1'b1, v, 10'h000);
            bus(8'h90, 1'b0, 8'h00, {2'b00, v[7:2], 2'b00});
            chk("trim", {4'h0, trim_code_out}, {4'h0, v[7:2]});
            bus(8'h94, 1'b1, v, 10'h000);
            bus(8'h94, 1'b0, 8'h00, {4'h0, v[5:4], 1'b1, v[2:0]});
            chk("oe", {4'h0, pin_oe_out}, {4'h0, ~v[5:4], 1'b0, ~v[2:0]});
            chk("pin", {4'h0, pin_out}, {4'h0, lfsr[13:8]});
        end
        results;
    end
endmodule
